/* src/lfr_pkg.sv */
// Constants and types shared by the LED problem reporting block
package lfr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] LFR_REPORT_CTRL_ADDR = 8'h05;
  localparam logic [7:0] LFR_STATUS_ADDR = 8'h07;
  localparam logic LFR_REPORT_ENABLE_RESET = 1'b1;
  localparam logic [7:0] LFR_STATUS_RESET = 8'h00;
  localparam logic [5:0] LFR_LATCH_RESET = 6'h00;
  localparam int LFR_REPORT_ENABLE_BIT = 0;

  // ----------------------------------------------------------------
  // Status field positions
  // ----------------------------------------------------------------
  localparam int LFR_GREEN_OPEN_BIT = 7;
  localparam int LFR_GREEN_SHORT_BIT = 6;
  localparam int LFR_BLUE_OPEN_BIT = 4;
  localparam int LFR_BLUE_SHORT_BIT = 3;
  localparam int LFR_RED_OPEN_BIT = 1;
  localparam int LFR_RED_SHORT_BIT = 0;

  // ----------------------------------------------------------------
  // Latch vector order
  // ----------------------------------------------------------------
  localparam int LFR_IDX_RED_SHORT = 0;
  localparam int LFR_IDX_RED_OPEN = 1;
  localparam int LFR_IDX_BLUE_SHORT = 2;
  localparam int LFR_IDX_BLUE_OPEN = 3;
  localparam int LFR_IDX_GREEN_SHORT = 4;
  localparam int LFR_IDX_GREEN_OPEN = 5;
  localparam int LFR_NUM_PROBLEMS = 6;

  // ----------------------------------------------------------------
  // Serial target
  // ----------------------------------------------------------------
  // Arbitrary neutral target address
  localparam logic [6:0] LFR_TARGET_ADDR = 7'h2a;
  localparam logic [3:0] LFR_BITS_PER_BYTE = 4'h8;
  localparam logic [7:0] LFR_UNMAPPED_READ = 8'h00;

  typedef enum logic [6:0] {
    LFR_ST_IDLE = 7'b0000001,
    LFR_ST_ADDR = 7'b0000010,
    LFR_ST_AACK = 7'b0000100,
    LFR_ST_WDATA = 7'b0001000,
    LFR_ST_WACK = 7'b0010000,
    LFR_ST_RDATA = 7'b0100000,
    LFR_ST_RACK = 7'b1000000
  } lfr_state_t;

endpackage

/* src/lfr_problem_latch.sv */
// Sticky per-channel open and short latches with pin synchronisers
`timescale 1ns/1ps
`default_nettype none
module lfr_problem_latch
  import lfr_pkg::*;
#(
  parameter int WIDTH = LFR_NUM_PROBLEMS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Detector levels from the analog side
  input wire logic [WIDTH-1:0] detect_i,
  // Clear pulse from a disable then enable sequence
  input wire logic clear_i,
  // Latched problems
  output logic [WIDTH-1:0] latched_o
);

  logic [WIDTH-1:0] sync1_reg;
  logic [WIDTH-1:0] sync2_reg;
  logic [WIDTH-1:0] latched_reg;
  logic [WIDTH-1:0] latched_next;

  // ----------------------------------------------------------------
  // Latch update, a new detection beats the clear
  // ----------------------------------------------------------------
  assign latched_next = (clear_i ? '0 : latched_reg) | sync2_reg;
  assign latched_o = latched_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      latched_reg <= LFR_LATCH_RESET;
    end else begin
      sync1_reg <= detect_i;
      sync2_reg <= sync1_reg;
      latched_reg <= latched_next;
    end
  end

endmodule
`default_nettype wire

/* src/lfr_top.sv */
// LED problem reporting block with its serial register target
`timescale 1ns/1ps
`default_nettype none
module lfr_top
  import lfr_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = LFR_TARGET_ADDR
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // Serial bus pins, open drain data
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  // Detector levels
  input wire logic GREEN_OPEN_I,
  input wire logic GREEN_SHORT_I,
  input wire logic BLUE_OPEN_I,
  input wire logic BLUE_SHORT_I,
  input wire logic RED_OPEN_I,
  input wire logic RED_SHORT_I,
  // Alert pin
  output logic ALERT_O
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  lfr_state_t state_reg;
  lfr_state_t state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic rw_reg;
  logic rw_next;
  logic first_reg;
  logic first_next;
  logic nack_reg;
  logic nack_next;
  logic enable_reg;
  logic enable_next;
  logic alert_reg;
  logic byte_done;
  logic addr_match;
  logic wr_stb;
  logic wr_ctrl;
  logic clear_pulse;
  logic [5:0] detect;
  logic [5:0] latched;
  logic [7:0] status_word;
  logic [7:0] rd_word;

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] read_reg(input logic [7:0] addr,
                                          input logic en,
                                          input logic [7:0] status);
    logic [7:0] word;
    word = LFR_UNMAPPED_READ;
    if (addr == LFR_REPORT_CTRL_ADDR) begin
      word[LFR_REPORT_ENABLE_BIT] = en;
    end else if (addr == LFR_STATUS_ADDR) begin
      word = status;
    end
    return word;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers and bus events
  // ----------------------------------------------------------------
  assign scl_s = scl_sync_reg[1];
  assign sda_s = sda_sync_reg[1];
  assign scl_rise = scl_s & ~scl_sync_reg[2];
  assign scl_fall = ~scl_s & scl_sync_reg[2];
  assign start_seen = scl_s & scl_sync_reg[2] & ~sda_s & sda_sync_reg[2];
  assign stop_seen = scl_s & scl_sync_reg[2] & sda_s & ~sda_sync_reg[2];

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], SCL_I};
      sda_sync_reg <= {sda_sync_reg[1:0], SDA_I};
    end
  end

  // ----------------------------------------------------------------
  // Problem latches and status word
  // ----------------------------------------------------------------
  assign detect[LFR_IDX_RED_SHORT] = RED_SHORT_I;
  assign detect[LFR_IDX_RED_OPEN] = RED_OPEN_I;
  assign detect[LFR_IDX_BLUE_SHORT] = BLUE_SHORT_I;
  assign detect[LFR_IDX_BLUE_OPEN] = BLUE_OPEN_I;
  assign detect[LFR_IDX_GREEN_SHORT] = GREEN_SHORT_I;
  assign detect[LFR_IDX_GREEN_OPEN] = GREEN_OPEN_I;

  lfr_problem_latch #(
    .WIDTH(LFR_NUM_PROBLEMS)
  ) u_latch (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .detect_i(detect),
    .clear_i(clear_pulse),
    .latched_o(latched)
  );

  always_comb begin
    status_word = LFR_STATUS_RESET;
    status_word[LFR_GREEN_OPEN_BIT] = latched[LFR_IDX_GREEN_OPEN];
    status_word[LFR_GREEN_SHORT_BIT] = latched[LFR_IDX_GREEN_SHORT];
    status_word[LFR_BLUE_OPEN_BIT] = latched[LFR_IDX_BLUE_OPEN];
    status_word[LFR_BLUE_SHORT_BIT] = latched[LFR_IDX_BLUE_SHORT];
    status_word[LFR_RED_OPEN_BIT] = latched[LFR_IDX_RED_OPEN];
    status_word[LFR_RED_SHORT_BIT] = latched[LFR_IDX_RED_SHORT];
  end

  // ----------------------------------------------------------------
  // Register writes and enable
  // ----------------------------------------------------------------
  assign wr_stb = scl_fall & (state_reg == LFR_ST_WACK) & ~first_reg;
  assign wr_ctrl = wr_stb & (ptr_reg == LFR_REPORT_CTRL_ADDR);
  assign enable_next = wr_ctrl ? shift_reg[LFR_REPORT_ENABLE_BIT]
                               : enable_reg;
  assign clear_pulse = wr_ctrl & shift_reg[LFR_REPORT_ENABLE_BIT]
                       & ~enable_reg;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      enable_reg <= LFR_REPORT_ENABLE_RESET;
      alert_reg <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      alert_reg <= enable_reg & (|latched);
    end
  end

  assign ALERT_O = alert_reg;

  // ----------------------------------------------------------------
  // Serial target sequencer
  // ----------------------------------------------------------------
  assign byte_done = (cnt_reg == LFR_BITS_PER_BYTE);
  assign addr_match = (shift_reg[7:1] == TARGET_ADDR);
  assign rd_word = read_reg(ptr_reg, enable_reg, status_word);

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    first_next = first_reg;
    nack_next = nack_reg;
    if (start_seen) begin
      state_next = LFR_ST_ADDR;
      cnt_next = 4'h0;
    end else if (stop_seen) begin
      state_next = LFR_ST_IDLE;
    end else if (scl_rise) begin
      if (state_reg == LFR_ST_RACK) begin
        nack_next = sda_s;
      end else if ((state_reg != LFR_ST_IDLE) & (state_reg != LFR_ST_AACK)
                   & (state_reg != LFR_ST_WACK)) begin
        // Acknowledge bits stay out of the shift register
        shift_next = {shift_reg[6:0], sda_s};
        cnt_next = cnt_reg + 4'h1;
      end
    end else if (scl_fall) begin
      case (state_reg)
        LFR_ST_ADDR: begin
          if (byte_done) begin
            rw_next = shift_reg[0];
            state_next = addr_match ? LFR_ST_AACK : LFR_ST_IDLE;
          end
        end
        LFR_ST_AACK: begin
          cnt_next = 4'h0;
          if (rw_reg) begin
            tx_next = rd_word;
            ptr_next = ptr_reg + 8'h01;
            state_next = LFR_ST_RDATA;
          end else begin
            first_next = 1'b1;
            state_next = LFR_ST_WDATA;
          end
        end
        LFR_ST_WDATA: begin
          if (byte_done) begin
            state_next = LFR_ST_WACK;
          end
        end
        LFR_ST_WACK: begin
          cnt_next = 4'h0;
          first_next = 1'b0;
          ptr_next = first_reg ? shift_reg : ptr_reg + 8'h01;
          state_next = LFR_ST_WDATA;
        end
        LFR_ST_RDATA: begin
          if (byte_done) begin
            state_next = LFR_ST_RACK;
          end else begin
            tx_next = {tx_reg[6:0], 1'b0};
          end
        end
        LFR_ST_RACK: begin
          cnt_next = 4'h0;
          if (nack_reg) begin
            state_next = LFR_ST_IDLE;
          end else begin
            tx_next = rd_word;
            ptr_next = ptr_reg + 8'h01;
            state_next = LFR_ST_RDATA;
          end
        end
        default: begin
          state_next = state_reg;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_reg <= LFR_ST_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      nack_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      first_reg <= first_next;
      nack_reg <= nack_next;
    end
  end

  // ----------------------------------------------------------------
  // Data pin drive, low only
  // ----------------------------------------------------------------
  assign SDA_O = 1'b0;
  assign SDA_OE_O = (state_reg == LFR_ST_AACK) | (state_reg == LFR_ST_WACK)
                    | ((state_reg == LFR_ST_RDATA) & ~tx_reg[7]);

endmodule
`default_nettype wire

/* test/lfr_props.sv */
// Port checker for the LED problem reporting block
`timescale 1ns/1ps
`default_nettype none
module lfr_props (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // Bus pins
  input wire logic SCL_I,
  input wire logic SDA_O,
  input wire logic SDA_OE_O,
  // Detectors and alert
  input wire logic GREEN_OPEN_I,
  input wire logic GREEN_SHORT_I,
  input wire logic BLUE_OPEN_I,
  input wire logic BLUE_SHORT_I,
  input wire logic RED_OPEN_I,
  input wire logic RED_SHORT_I,
  input wire logic ALERT_O
);
  // ----------
  // Bus activity
  // ----------
  wire logic [5:0] det;
  logic [4:0] quiet_reg;
  logic scl_reg;
  logic used_reg;
  assign det = {GREEN_OPEN_I, GREEN_SHORT_I, BLUE_OPEN_I, BLUE_SHORT_I,
    RED_OPEN_I, RED_SHORT_I};
  always_ff @(posedge CLK_I) begin
    scl_reg <= SCL_I;
    if (SYS_RST_I) begin
      quiet_reg <= 5'h1f;
      used_reg <= 1'b0;
    end else begin
      quiet_reg <= (SCL_I != scl_reg) ? 5'h00 :
        (quiet_reg == 5'h1f) ? quiet_reg : quiet_reg + 5'h01;
      used_reg <= used_reg | ~SCL_I;
    end
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  property p_reset_quiet;
    $fell(SYS_RST_I) |-> !ALERT_O && !SDA_OE_O;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("output active after reset");
  property p_alert_cause;
    $rose(ALERT_O) |-> $past(det, 4) != 6'h00;
  endproperty
  a_alert_cause: assert property (p_alert_cause)
    else $error("alert rose without detection");
  property p_alert_prompt;
    !used_reg && $rose(det != 6'h00) |-> ##4 ALERT_O;
  endproperty
  a_alert_prompt: assert property (p_alert_prompt)
    else $error("alert late");
  property p_alert_hold;
    $rose(ALERT_O) |=> ALERT_O [*8];
  endproperty
  a_alert_hold: assert property (p_alert_hold)
    else $error("alert dropped early");
  property p_alert_sticky;
    $fell(ALERT_O) |-> quiet_reg < 5'h14;
  endproperty
  a_alert_sticky: assert property (p_alert_sticky)
    else $error("alert fell without host write");
  property p_oe_scl_low;
    $changed(SDA_OE_O) |-> !SCL_I;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low)
    else $error("data drive changed with clock high");
  property p_idle_silent;
    !used_reg |-> !SDA_OE_O;
  endproperty
  a_idle_silent: assert property (p_idle_silent)
    else $error("data driven on idle bus");
  property p_sda_zero;
    SDA_OE_O |-> !SDA_O;
  endproperty
  a_sda_zero: assert property (p_sda_zero)
    else $error("data pin driven high");
  c_rise: cover property ($rose(ALERT_O));
  c_fall: cover property ($fell(ALERT_O));
  c_ack: cover property ($rose(SDA_OE_O));
endmodule
bind lfr_top lfr_props i_props (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
  .SCL_I(SCL_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
  .GREEN_OPEN_I(GREEN_OPEN_I), .GREEN_SHORT_I(GREEN_SHORT_I),
  .BLUE_OPEN_I(BLUE_OPEN_I), .BLUE_SHORT_I(BLUE_SHORT_I),
  .RED_OPEN_I(RED_OPEN_I), .RED_SHORT_I(RED_SHORT_I), .ALERT_O(ALERT_O));
`default_nettype wire

/* test/lfr_host.sv */
// Host controller model for the serial register bus
`timescale 1ns/1ps
`default_nettype none
module lfr_host
  import lfr_pkg::*;
(
  // Clock and data line level
  input wire logic clk_i,
  input wire logic sda_i,
  // Bus clock and data pull-down
  output logic scl_o,
  output logic pull_o
);
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  // ----------
  // Bit level
  // ----------
  task automatic tick();
    repeat (5) @(posedge clk_i);
  endtask
  task automatic bit_io(input logic b, output logic r);
    pull_o <= ~b;
    tick();
    scl_o <= 1'b1;
    tick();
    tick();
    r = sda_i;
    scl_o <= 1'b0;
    tick();
  endtask
  task automatic cond(input logic stop_n);
    pull_o <= stop_n ? 1'b0 : 1'b1;
    tick();
    scl_o <= 1'b1;
    tick();
    pull_o <= stop_n;
    tick();
    if (stop_n) begin
      scl_o <= 1'b0;
      tick();
    end
  endtask
  task automatic byte_io(input logic [7:0] d, output logic [7:0] q,
    output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // ----------
  // Register access
  // ----------
  task automatic xfer(input logic [7:0] a, input logic [7:0] d,
    input logic rd, output logic [7:0] q, output logic ok);
    logic k0, k1, k2;
    cond(1'b1);
    byte_io({LFR_TARGET_ADDR, 1'b0}, q, k0);
    byte_io(a, q, k1);
    if (rd) begin
      cond(1'b1);
      byte_io({LFR_TARGET_ADDR, 1'b1}, q, k2);
      byte_io(8'hff, q, ok);
    end else begin
      byte_io(d, q, k2);
    end
    cond(1'b0);
    ok = k0 & k1 & k2;
  endtask
  // Address phase only, to a chosen target address
  task automatic probe(input logic [6:0] ta, output logic ack);
    logic [7:0] q;
    cond(1'b1);
    byte_io({ta, 1'b0}, q, ack);
    cond(1'b0);
  endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the LED problem reporting block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import lfr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [5:0] det = 6'h00;
  logic scl, pull, sda_oe, sda_out, alert, ok;
  logic [7:0] q;
  wire logic sda;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  always #10 clk = ~clk;
  // Open-drain data line with pull-up
  assign sda = ~(pull | (sda_oe & ~sda_out));
  lfr_top i_dut (.CLK_I(clk), .SYS_RST_I(rst), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_out), .SDA_OE_O(sda_oe), .GREEN_OPEN_I(det[5]),
    .GREEN_SHORT_I(det[4]), .BLUE_OPEN_I(det[3]), .BLUE_SHORT_I(det[2]),
    .RED_OPEN_I(det[1]), .RED_SHORT_I(det[0]), .ALERT_O(alert));
  lfr_host i_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .pull_o(pull));
  // ----------
  // Helpers
  // ----------
  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(input logic [7:0] a, input logic [7:0] d,
    input logic rd);
    i_host.xfer(a, d, rd, q, ok);
    chk("ack", 8'h01, {7'h00, ok});
    if (rd) begin
      chk("read", d, q);
    end
  endtask
  task automatic pulse(input logic [5:0] m);
    det <= m;
    repeat (2) @(posedge clk);
    det <= 6'h00;
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [7:0] stat(input logic [5:0] d);
    return {d[5], d[4], 1'b0, d[3], d[2], 1'b0, d[1], d[0]};
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      close_out();
    end
  end
  // ----------
  // Tests
  // ----------
  initial begin
    logic [5:0] m;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      m = 6'h01 << i;
      pulse(m);
      chk("alert", 8'h01, {7'h00, alert});
      acc(LFR_STATUS_ADDR, stat(m), 1'b1);
      acc(LFR_STATUS_ADDR, 8'hff, 1'b0);
      acc(LFR_STATUS_ADDR, stat(m), 1'b1);
      acc(LFR_REPORT_CTRL_ADDR, 8'h00, 1'b0);
      chk("alert off", 8'h00, {7'h00, alert});
      pulse(6'h20 >> i);
      chk("alert gated", 8'h00, {7'h00, alert});
      acc(LFR_STATUS_ADDR, stat(m | (6'h20 >> i)), 1'b1);
      acc(LFR_REPORT_CTRL_ADDR, 8'h00, 1'b1);
      acc(LFR_REPORT_CTRL_ADDR, 8'hff, 1'b0);
      acc(LFR_REPORT_CTRL_ADDR, 8'h01, 1'b1);
      acc(LFR_STATUS_ADDR, 8'h00, 1'b1);
      $display("test channel %0d done", i);
    end
    acc(8'h04, LFR_UNMAPPED_READ, 1'b1);
    i_host.probe(LFR_TARGET_ADDR ^ 7'h01, ok);
    chk("foreign ack", 8'h00, {7'h00, ok});
    pulse(6'h04);
    acc(LFR_REPORT_CTRL_ADDR, 8'h01, 1'b0);
    acc(LFR_STATUS_ADDR, stat(6'h04), 1'b1);
    chk("alert kept", 8'h01, {7'h00, alert});
    $display("test refusal and hold done");
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("alert reset", 8'h00, {7'h00, alert});
    acc(LFR_STATUS_ADDR, LFR_STATUS_RESET, 1'b1);
    acc(LFR_REPORT_CTRL_ADDR, 8'h01, 1'b1);
    $display("test reset done");
    close_out();
  end
endmodule
`default_nettype wire
